// >>> pcie_err_classifier.sv
`timescale 1ns/1ns
`default_nettype none
// What this block does
// - Symbol, disparity, decode, framing errors are correctable
// - Link training protocol violation is uncorrectable
// - Nullified ENDB packet dropped without error
// - Other bad LCRC is correctable
// - Unexpected non-duplicate sequence number is correctable
// - DLLP with failing CRC is correctable
// - Flow control init violation is uncorrectable
// - Stray acknowledge sequence number is uncorrectable
// - Surprise link-down fatal only when checking enabled
// - Poisoned: non-fatal at destination, advisory when forwarded
// - Check digest when enabled, log failing header
// - Digest failure at destination is non-fatal
// - Digest failure when forwarding is advisory correctable
// - Unsupported request logged; non-posted advisory, else non-fatal
// - No completer abort or completion timeout checks
// - Overflow sets debug flag, fatal, no header log
// - No flow control protocol error checking
// - Malformed packet is fatal with header logged
// - Length field versus payload mismatch is malformed
module pcie_err_classifier
  import pcie_err_pkg::*;
(
  input  wire logic             clk_sys,
  input  wire logic             sys_rst,
  // Physical layer events, one-cycle pulses
  input  wire logic             phy_invalid_symbol,
  input  wire logic             phy_disparity_err,
  input  wire logic             phy_decode_err,
  input  wire logic             phy_framing_err,
  input  wire logic             phy_train_violation,
  // Received TLP at the data link layer
  input  wire logic             dl_tlp_end,
  input  wire logic             dl_tlp_endb,
  input  wire logic [CRC_W-1:0] dl_lcrc_rx,
  input  wire logic [CRC_W-1:0] dl_lcrc_calc,
  input  wire logic [SEQ_W-1:0] dl_seq,
  // Received DLLPs
  input  wire logic             dl_dllp_end,
  input  wire logic             dl_dllp_crc_bad,
  // Flow control setup monitor
  input  wire logic             dl_fc_init_violation,
  // Acknowledge tracking against the transmit side
  input  wire logic             dl_ack_valid,
  input  wire logic [SEQ_W-1:0] dl_ack_seq,
  input  wire logic [SEQ_W-1:0] dl_next_tx_seq,
  // Link-down event and its enable
  input  wire logic             dl_surprise_down,
  input  wire logic             surprise_down_chk_en,
  // Transaction layer view of an accepted TLP
  input  wire logic             tl_valid,
  input  wire logic             tl_final_dest,
  input  wire logic             tl_poisoned,
  input  wire logic             tl_unsupported,
  input  wire logic             tl_non_posted,
  input  wire logic             tl_malformed,
  // Digest fields of the same packet
  input  wire logic             tl_td,
  input  wire logic [CRC_W-1:0] tl_ecrc_rx,
  input  wire logic [CRC_W-1:0] tl_ecrc_calc,
  // Payload size fields of the same packet
  input  wire logic             tl_has_data,
  input  wire logic [LEN_W-1:0] tl_length,
  input  wire logic [PAY_W-1:0] tl_payload_dw,
  // Static control, set by software
  input  wire logic             ecrc_chk_en,
  // Buffer overflow pulse, independent of packets
  input  wire logic             tl_rx_overflow,
  // Uncorrectable severity: high routes to fatal
  input  wire logic             uncor_sev_fatal,
  // Clears the overflow flag in debug status
  input  wire logic             dbg_clear,
  // Results toward error reporting
  output logic                  err_cor,
  output logic                  err_nonfatal,
  output logic                  err_fatal,
  output logic                  hdr_log,
  output logic                  tlp_discard,
  // Overflow flag lives in its own bit, the rest read zero
  output logic [DBG_W-1:0]      tl_debug_status
);

  // One comparison block serves both layers. The link fields and the
  // transaction fields arrive at different times, but each result is
  // only used while its own strobe is high, so sharing is safe.
  tlp_check_if chk ();  // Comparison results from the checker

  // Drive the checker; data link fields and transaction fields share it
  // Link CRC fields, qualified by the packet end strobe
  assign chk.lcrc_rx    = dl_lcrc_rx;
  assign chk.lcrc_calc  = dl_lcrc_calc;
  assign chk.endb       = dl_tlp_endb;
  // Digest fields, qualified by the transaction strobe
  assign chk.ecrc_rx    = tl_ecrc_rx;
  assign chk.ecrc_calc  = tl_ecrc_calc;
  assign chk.td         = tl_td;
  assign chk.ecrc_en    = ecrc_chk_en;
  // Length fields for the payload size check
  assign chk.has_data   = tl_has_data;
  assign chk.length     = tl_length;
  assign chk.payload_dw = tl_payload_dw;

  // Purely combinational; results settle within the same cycle
  tlp_check u_check (
    .chk (chk)
  );

  // Sequence tracking state
  // Receive and transmit sides are tracked independently
  logic [SEQ_W-1:0] next_rcv_seq;       // Expected receive sequence
  logic [SEQ_W-1:0] next_next_rcv_seq;
  logic [SEQ_W-1:0] ackd_seq;           // Last acknowledged value
  logic [SEQ_W-1:0] next_ackd_seq;
  // Distances wrap with the sequence space, so no wrap logic is needed
  logic [SEQ_W-1:0] rcv_dist;           // Distance from expected
  logic [SEQ_W-1:0] ack_dist;           // Ack distance past last acked
  logic [SEQ_W-1:0] out_dist;           // Outstanding span plus one
  // Error terms feed the classification below
  logic             seq_err;            // Out of order, not duplicate
  logic             ack_err;            // Ack neither outstanding nor last acked

  // Registered outputs and debug status
  logic             next_err_cor;
  logic             next_err_nonfatal;
  logic             next_err_fatal;
  logic             next_hdr_log;
  logic             next_tlp_discard;
  logic [DBG_W-1:0] next_tl_debug_status;

  // Per-cycle classification terms
  logic             phy_cor;            // Physical layer correctable
  logic             dl_cor;             // Data link correctable
  logic             uncor;              // Uncorrectable, severity pending
  logic             tl_nonfatal;        // Transaction layer non-fatal
  logic             tl_cor;             // Advisory correctable
  logic             tl_fatal;           // Transaction layer fatal
  logic             tl_log;             // Header must be logged
  logic             malformed;          // Any malformed verdict

  // Sequence number bookkeeping
  // Duplicates are told apart by half the sequence space
  always_comb begin
    // Defaults: hold state, no error
    next_next_rcv_seq = next_rcv_seq;
    next_ackd_seq     = ackd_seq;
    rcv_dist          = dl_seq - next_rcv_seq;
    ack_dist          = dl_ack_seq - ackd_seq;
    out_dist          = dl_next_tx_seq - ackd_seq;
    seq_err           = 1'b0;
    ack_err           = 1'b0;
    // Only good, non-nullified packets reach sequence checking
    if (dl_tlp_end && !chk.nullified && !chk.lcrc_bad) begin
      if (rcv_dist == SEQ_RESET) begin
        // In order: accept and advance
        next_next_rcv_seq = next_rcv_seq + SEQ_ONE;
      end else if (rcv_dist < SEQ_HALF) begin
        // Ahead of expected means packets were lost
        seq_err = 1'b1;
      end
      // Behind expected is a duplicate replay: dropped quietly
      // A gap of half the space or more reads as a replay
    end
    // Valid acks fall between last acked and last transmitted
    if (dl_ack_valid) begin
      if (ack_dist < out_dist) begin
        // Retires everything up to and including this one
        next_ackd_seq = dl_ack_seq;
      end else begin
        // Neither outstanding nor the last acked value
        ack_err = 1'b1;
      end
    end
  end

  // Layer by layer classification
  // A cycle may carry events of every layer at once
  always_comb begin
    // Receiver symbol level faults
    phy_cor  = phy_invalid_symbol || phy_disparity_err
               || phy_decode_err || phy_framing_err;

    // Link layer faults; a nullified packet raises nothing
    dl_cor   = (dl_tlp_end && chk.lcrc_bad)
               || seq_err
               || (dl_dllp_end && dl_dllp_crc_bad);

    // Protocol violations by the partner
    uncor    = phy_train_violation
               || dl_fc_init_violation
               || ack_err;

    // Length disagreement joins other malformed checks
    malformed = tl_valid && (tl_malformed || chk.len_bad);
    // Defaults: no transaction layer verdict
    tl_nonfatal = 1'b0;
    tl_cor      = 1'b0;
    tl_fatal    = 1'b0;
    tl_log      = 1'b0;
    // No completer abort or timeout: never a requester
    // No flow control protocol check exists here
    if (tl_valid) begin
      if (malformed) begin
        // Malformed overrides every other verdict
        tl_fatal = 1'b1;
        tl_log   = 1'b1;
      end else begin
        // Verdicts below may stack; the outputs OR them
        if (tl_poisoned) begin
          // Destination owns the data; forwarder only advises
          if (tl_final_dest) begin
            tl_nonfatal = 1'b1;
          end else begin
            // Forwarded poisoned data is only advisory
            tl_cor = 1'b1;
          end
          tl_log = 1'b1;
        end
        if (chk.ecrc_bad) begin
          // Forwarding case stays advisory correctable
          if (tl_final_dest) begin
            tl_nonfatal = 1'b1;
          end else begin
            // Final receiver reports it, so only advise here
            tl_cor = 1'b1;
          end
          tl_log = 1'b1;
        end
        if (tl_unsupported) begin
          // Requester learns via completion, so advisory only
          if (tl_non_posted) begin
            tl_cor = 1'b1;
          end else begin
            // Posted request: nobody else will report it
            tl_nonfatal = 1'b1;
          end
          tl_log = 1'b1;
        end
      end
    end
    // Overflow is fatal but the header may be lost, so no log
    // It shares the fatal pulse with any other fatal event
    if (tl_rx_overflow) begin
      tl_fatal = 1'b1;
    end
  end

  // Merge into severity pulses and debug status
  // One pulse per output per cycle, however many causes
  always_comb begin
    // Correctable from every layer
    next_err_cor      = phy_cor || dl_cor || tl_cor;
    // Uncorrectable split by the chosen severity
    next_err_nonfatal = tl_nonfatal || (uncor && !uncor_sev_fatal);
    // Surprise down stays silent unless enabled
    next_err_fatal    = tl_fatal || (uncor && uncor_sev_fatal)
                        || (dl_surprise_down && surprise_down_chk_en);
    // Only the transaction layer logs headers
    next_hdr_log      = tl_log;
    // Nullified packets are dropped, nothing more
    next_tlp_discard  = dl_tlp_end && chk.nullified;
    // Debug status keeps its value unless changed below
    next_tl_debug_status = tl_debug_status;
    // Clear first so a same-cycle overflow still sets the flag
    // Set wins over clear, so no overflow goes unseen
    if (dbg_clear) begin
      next_tl_debug_status[DBG_OVF_BIT] = 1'b0;
    end
    if (tl_rx_overflow) begin
      next_tl_debug_status[DBG_OVF_BIT] = 1'b1;
    end
  end

  // Register all state; outputs pulse one cycle after the event
  // Synchronous reset, so every register sees the same edge
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      // Expect sequence zero, nothing acknowledged yet
      next_rcv_seq    <= SEQ_RESET;
      ackd_seq        <= ACKD_RESET;
      err_cor         <= 1'b0;
      err_nonfatal    <= 1'b0;
      err_fatal       <= 1'b0;
      hdr_log         <= 1'b0;
      tlp_discard     <= 1'b0;
      tl_debug_status <= DBG_RESET;
    end else begin
      // Pulses last one cycle because next values are
      // recomputed from fresh inputs every cycle
      next_rcv_seq    <= next_next_rcv_seq;
      ackd_seq        <= next_ackd_seq;
      err_cor         <= next_err_cor;
      err_nonfatal    <= next_err_nonfatal;
      err_fatal       <= next_err_fatal;
      hdr_log         <= next_hdr_log;
      tlp_discard     <= next_tlp_discard;
      tl_debug_status <= next_tl_debug_status;
    end
  end

endmodule : pcie_err_classifier
`default_nettype wire

// >>> pcie_err_pkg.sv
package pcie_err_pkg;
  // Link sequence numbers wrap modulo 4096
  localparam int unsigned SEQ_W       = 12;
  // Half the sequence space: older values are duplicates
  localparam logic [11:0] SEQ_HALF    = 12'h800;
  localparam logic [11:0] SEQ_RESET   = 12'h000;
  // Last acknowledged value after reset is one below zero
  localparam logic [11:0] ACKD_RESET  = 12'hfff;
  localparam logic [11:0] SEQ_ONE     = 12'h001;
  localparam int unsigned CRC_W       = 32;
  // TLP length field and payload count in doublewords
  localparam int unsigned LEN_W       = 10;
  localparam int unsigned PAY_W       = 11;
  // A zero length field means the largest payload
  localparam logic [9:0]  LEN_ZERO    = 10'h000;
  localparam logic [10:0] LEN_MAX_DW  = 11'h400;
  // Transaction-layer debug status layout
  localparam int unsigned DBG_W       = 8;
  localparam int unsigned DBG_OVF_BIT = 0;
  localparam logic [7:0]  DBG_RESET   = 8'h00;
endpackage : pcie_err_pkg

// >>> tlp_check_if.sv
`timescale 1ns/1ns
`default_nettype none
// Per-packet CRC and length comparisons between classifier and checker
interface tlp_check_if;
  import pcie_err_pkg::*;
  logic [CRC_W-1:0] lcrc_rx;     // LCRC as received
  logic [CRC_W-1:0] lcrc_calc;   // LCRC computed locally
  logic             endb;        // Packet ended with ENDB
  logic [CRC_W-1:0] ecrc_rx;     // Digest as received
  logic [CRC_W-1:0] ecrc_calc;   // Digest computed locally
  logic             td;          // Header digest bit
  logic             ecrc_en;     // Digest checking enabled
  logic             has_data;    // Format says payload present
  logic [LEN_W-1:0] length;      // Length field
  logic [PAY_W-1:0] payload_dw;  // Doublewords actually received
  logic             nullified;   // Nullified packet, drop silently
  logic             lcrc_bad;    // Real LCRC error
  logic             ecrc_bad;    // Digest failure
  logic             len_bad;     // Length disagrees with payload
  modport classifier (output lcrc_rx, lcrc_calc, endb, ecrc_rx, ecrc_calc, td, ecrc_en,
                      has_data, length, payload_dw,
                      input  nullified, lcrc_bad, ecrc_bad, len_bad);
  modport compare    (input  lcrc_rx, lcrc_calc, endb, ecrc_rx, ecrc_calc, td, ecrc_en,
                      has_data, length, payload_dw,
                      output nullified, lcrc_bad, ecrc_bad, len_bad);
endinterface : tlp_check_if
`default_nettype wire

// >>> tlp_check.sv
`timescale 1ns/1ns
`default_nettype none
// Pure comparisons; the classifier registers the results
module tlp_check
  import pcie_err_pkg::*;
(
  tlp_check_if.compare chk
);
  logic [PAY_W-1:0] expect_dw;  // Payload size the length field implies

  // Nullify, CRC and length comparisons
  always_comb begin
    // ENDB with inverted LCRC is a deliberate nullify
    chk.nullified = chk.endb && (chk.lcrc_rx == ~chk.lcrc_calc);
    // Any other mismatch is a true link error
    chk.lcrc_bad  = !chk.nullified && (chk.lcrc_rx != chk.lcrc_calc);
    // Digest only checked when enabled and present
    chk.ecrc_bad  = chk.ecrc_en && chk.td && (chk.ecrc_rx != chk.ecrc_calc);
    // Zero length field stands for the largest payload
    if (chk.length == LEN_ZERO) begin
      expect_dw = LEN_MAX_DW;
    end else begin
      expect_dw = {1'b0, chk.length};
    end
    chk.len_bad   = chk.has_data && (expect_dw != chk.payload_dw);
  end
endmodule : tlp_check
`default_nettype wire

// >>> err_cls_asserts.sv
`timescale 1ns/1ns
`default_nettype none
// Severity routing checks, seen from the classifier ports only
module err_cls_checker
  import pcie_err_pkg::*;
(
  input wire logic             clk_sys,
  input wire logic             sys_rst,
  input wire logic             phy_invalid_symbol,
  input wire logic             phy_disparity_err,
  input wire logic             phy_decode_err,
  input wire logic             phy_framing_err,
  input wire logic             phy_train_violation,
  input wire logic             dl_tlp_end,
  input wire logic             dl_tlp_endb,
  input wire logic [CRC_W-1:0] dl_lcrc_rx,
  input wire logic [CRC_W-1:0] dl_lcrc_calc,
  input wire logic             dl_dllp_end,
  input wire logic             dl_dllp_crc_bad,
  input wire logic             dl_fc_init_violation,
  input wire logic             tl_valid,
  input wire logic             tl_malformed,
  input wire logic             tl_rx_overflow,
  input wire logic             uncor_sev_fatal,
  input wire logic             err_cor,
  input wire logic             err_nonfatal,
  input wire logic             err_fatal,
  input wire logic             hdr_log,
  input wire logic             tlp_discard,
  input wire logic [DBG_W-1:0] tl_debug_status
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  // Any receiver symbol level fault
  sequence s_phy_fault;
    phy_invalid_symbol || phy_disparity_err || phy_decode_err || phy_framing_err;
  endsequence
  // Overflow lands on fatal and the debug flag together
  sequence s_ovf_set;
    err_fatal && tl_debug_status[DBG_OVF_BIT];
  endsequence
  property p_phy_cor; s_phy_fault |=> err_cor; endproperty
  property p_train; phy_train_violation && uncor_sev_fatal |=> err_fatal; endproperty
  property p_fc_init; dl_fc_init_violation && !uncor_sev_fatal |=> err_nonfatal; endproperty
  property p_nullified;
    dl_tlp_end && dl_tlp_endb && dl_lcrc_rx == ~dl_lcrc_calc |=> tlp_discard;
  endproperty
  // Nullified packets are excluded, they are only dropped
  property p_lcrc;
    dl_tlp_end && dl_lcrc_rx != dl_lcrc_calc
      && !(dl_tlp_endb && dl_lcrc_rx == ~dl_lcrc_calc) |=> err_cor;
  endproperty
  property p_dllp; dl_dllp_end && dl_dllp_crc_bad |=> err_cor; endproperty
  property p_ovf; tl_rx_overflow |=> s_ovf_set; endproperty
  // Flag only rises right after an overflow
  property p_flag_cause; $rose(tl_debug_status[DBG_OVF_BIT]) |-> $past(tl_rx_overflow); endproperty
  property p_malformed; tl_valid && tl_malformed |=> err_fatal && hdr_log; endproperty
  a_phy_cor: assert property (p_phy_cor) else $error("phy fault not correctable");
  a_train: assert property (p_train) else $error("training fault not fatal");
  a_fc_init: assert property (p_fc_init) else $error("fc init fault not nonfatal");
  a_nullified: assert property (p_nullified) else $error("nullified not dropped");
  a_lcrc: assert property (p_lcrc) else $error("bad lcrc not correctable");
  a_dllp: assert property (p_dllp) else $error("bad dllp not correctable");
  a_ovf: assert property (p_ovf) else $error("overflow not fatal or flagged");
  a_flag_cause: assert property (p_flag_cause) else $error("flag rose alone");
  a_malformed: assert property (p_malformed) else $error("malformed not fatal");
endmodule : err_cls_checker
bind pcie_err_classifier err_cls_checker chk_i (
  .clk_sys(clk_sys), .sys_rst(sys_rst), .phy_invalid_symbol(phy_invalid_symbol),
  .phy_disparity_err(phy_disparity_err), .phy_decode_err(phy_decode_err),
  .phy_framing_err(phy_framing_err), .phy_train_violation(phy_train_violation),
  .dl_tlp_end(dl_tlp_end), .dl_tlp_endb(dl_tlp_endb), .dl_lcrc_rx(dl_lcrc_rx),
  .dl_lcrc_calc(dl_lcrc_calc), .dl_dllp_end(dl_dllp_end), .dl_dllp_crc_bad(dl_dllp_crc_bad),
  .dl_fc_init_violation(dl_fc_init_violation), .tl_valid(tl_valid),
  .tl_malformed(tl_malformed), .tl_rx_overflow(tl_rx_overflow),
  .uncor_sev_fatal(uncor_sev_fatal), .err_cor(err_cor), .err_nonfatal(err_nonfatal),
  .err_fatal(err_fatal), .hdr_log(hdr_log), .tlp_discard(tlp_discard),
  .tl_debug_status(tl_debug_status));
`default_nettype wire

// >>> link_partner.sv
`timescale 1ns/1ns
`default_nettype none
// Far link end: one TLP per request, fields scrambled when idle
module link_partner
  import pcie_err_pkg::*;
(
  input  wire logic             clk_sys,
  input  wire logic             go,        // Send one packet
  input  wire logic [1:0]       kind,      // 0 good, 1 bad LCRC, 2 nullified
  input  wire logic [SEQ_W-1:0] seq,
  output logic                  tlp_end,
  output logic                  endb,
  output logic [CRC_W-1:0]      lcrc_rx,
  output logic [CRC_W-1:0]      lcrc_calc,
  output logic [SEQ_W-1:0]      tlp_seq
);
  logic [CRC_W-1:0] crc; // Fresh CRC each cycle
  initial {tlp_end, endb, lcrc_rx, lcrc_calc, tlp_seq} = '0;
  // Idle fields invert so a stale value never looks valid
  always @(posedge clk_sys) begin
    crc = $urandom;
    tlp_end <= go;
    endb <= go && kind == 2'd2;
    lcrc_calc <= crc;
    lcrc_rx <= !go ? ~lcrc_rx :
               kind == 2'd0 ? crc : kind == 2'd1 ? crc ^ 32'h1 : ~crc;
    tlp_seq <= go ? seq : ~tlp_seq;
  end
endmodule : link_partner
`default_nettype wire

// >>> testbench.sv
`timescale 1ns/1ns
`default_nettype none
// Corner and random traffic, every output checked after each step
module testbench;
  import pcie_err_pkg::*;
  logic             clk_sys, sys_rst, flag, go;
  logic [4:0]       phy; // Symbol, disparity, decode, framing, training
  logic             dllp_end, dllp_bad, fc_viol, ack_v, sdown, sd_en, ovf, sev_fatal, dbg_clr;
  logic             tv, fin, pois, ur, np, mal, td, ecrc_en, hasd, p_end, p_endb;
  logic             cor, nf, fat, hdr, disc;
  logic [1:0]       kind;
  logic [SEQ_W-1:0] ack_seq, next_tx, pseq, p_seq;
  logic [CRC_W-1:0] ecrc_rx, ecrc_calc, p_lrx, p_lcalc;
  logic [LEN_W-1:0] len;
  logic [PAY_W-1:0] pay;
  logic [DBG_W-1:0] dbg;
  int               num_errors, checks;
  pcie_err_classifier uut (.clk_sys(clk_sys), .sys_rst(sys_rst), .phy_invalid_symbol(phy[0]),
    .phy_disparity_err(phy[1]), .phy_decode_err(phy[2]), .phy_framing_err(phy[3]),
    .phy_train_violation(phy[4]), .dl_tlp_end(p_end), .dl_tlp_endb(p_endb),
    .dl_lcrc_rx(p_lrx), .dl_lcrc_calc(p_lcalc), .dl_seq(p_seq), .dl_dllp_end(dllp_end),
    .dl_dllp_crc_bad(dllp_bad), .dl_fc_init_violation(fc_viol), .dl_ack_valid(ack_v),
    .dl_ack_seq(ack_seq), .dl_next_tx_seq(next_tx), .dl_surprise_down(sdown),
    .surprise_down_chk_en(sd_en), .tl_valid(tv), .tl_final_dest(fin), .tl_poisoned(pois),
    .tl_unsupported(ur), .tl_non_posted(np), .tl_malformed(mal), .tl_td(td),
    .tl_ecrc_rx(ecrc_rx), .tl_ecrc_calc(ecrc_calc), .tl_has_data(hasd), .tl_length(len),
    .tl_payload_dw(pay), .ecrc_chk_en(ecrc_en), .tl_rx_overflow(ovf),
    .uncor_sev_fatal(sev_fatal), .dbg_clear(dbg_clr), .err_cor(cor), .err_nonfatal(nf),
    .err_fatal(fat), .hdr_log(hdr), .tlp_discard(disc), .tl_debug_status(dbg));
  link_partner lp (.clk_sys(clk_sys), .go(go), .kind(kind), .seq(pseq), .tlp_end(p_end),
    .endb(p_endb), .lcrc_rx(p_lrx), .lcrc_calc(p_lcalc), .tlp_seq(p_seq));
  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    checks++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  // Drops every pulse input, levels stay
  task automatic idle();
    {phy, dllp_end, fc_viol, ack_v, sdown, ovf, dbg_clr, tv, go} = '0;
  endtask : idle
  // Expected {cor, nonfatal, fatal, hdr, discard} from the present inputs
  function automatic logic [4:0] verdict(input logic [4:0] extra);
    logic c, n, f, h, m, eb;
    c = |phy[3:0] | (dllp_end & dllp_bad);
    f = (sdown & sd_en) | ovf;
    n = 1'b0;
    h = 1'b0;
    eb = td & ecrc_en & (ecrc_rx != ecrc_calc);
    m = mal | (hasd && pay != (len == LEN_ZERO ? LEN_MAX_DW : {1'b0, len}));
    if (tv && m) {f, h} = 2'b11;
    else if (tv) begin
      h = pois | ur | eb;
      n = (fin & (pois | eb)) | (ur & ~np);
      c = c | (~fin & (pois | eb)) | (ur & np);
    end
    if (phy[4] | fc_viol) {f, n} = {f, n} | (sev_fatal ? 2'b10 : 2'b01);
    return {c, n, f, h, 1'b0} | extra;
  endfunction : verdict
  task automatic step(input logic [4:0] extra);
    logic [4:0] e;
    e = verdict(extra);
    flag = ovf | (flag & ~dbg_clr); // Set beats clear
    @(posedge clk_sys);
    @(negedge clk_sys);
    chk("verdict", {3'h0, e}, {3'h0, cor, nf, fat, hdr, disc});
    chk("debug", {7'h00, flag}, dbg);
  endtask : step
  // Partner needs one extra cycle to put the packet on the wire
  task automatic send(input logic [1:0] k, input logic [SEQ_W-1:0] s, input logic [4:0] x);
    go = 1'b1;
    kind = k;
    pseq = s;
    @(negedge clk_sys);
    go = 1'b0;
    step(x);
  endtask : send
  task automatic ack(input logic [SEQ_W-1:0] s, input logic [4:0] x);
    ack_v = 1'b1;
    ack_seq = s;
    step(x);
  endtask : ack
  task automatic stop_test();
    $display("errors %0d checks %0d", num_errors, checks);
    if (num_errors == 0 && checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : stop_test
  // Generous bound: the sequence needs a few hundred cycles
  initial begin
    #(40 * 5000);
    num_errors++;
    stop_test();
  end
  initial begin
    idle();
    sys_rst = 1'b1;
    {flag, sd_en, sev_fatal, dllp_bad, fin, pois, ur, np, mal, td, ecrc_en, hasd} = '0;
    {kind, pseq, ack_seq, ecrc_rx, ecrc_calc, len, pay} = '0;
    next_tx = 12'h003;
    num_errors = 0;
    checks = 0;
    void'($urandom(32'ha154));
    repeat (10) @(negedge clk_sys);
    sys_rst = 1'b0;
    step(5'h00);
    send(2'd0, 12'h000, 5'h00);
    send(2'd0, 12'h005, 5'h10);
    send(2'd0, 12'h000, 5'h00);
    send(2'd1, 12'h001, 5'h10);
    send(2'd2, 12'h001, 5'h01);
    send(2'd0, 12'h001, 5'h00);
    ack(12'h001, 5'h00);
    ack(12'h001, 5'h00);
    ack(12'h005, 5'h08);
    ack_v = 1'b0; // Acks end here; the loop leaves them low
    // Sparse pulses, random levels, lengths around zero and full size
    repeat (300) begin
      {phy, dllp_end, fc_viol, sdown, ovf, dbg_clr} = 10'($urandom & $urandom & $urandom);
      {tv, dllp_bad, sd_en, sev_fatal, fin, pois, ur, np, td, ecrc_en, hasd} = 11'($urandom);
      mal = ($urandom % 8) == 0;
      len = 10'($urandom % 3);
      pay = ($urandom % 4 == 0) ? LEN_MAX_DW : 11'($urandom % 3);
      ecrc_rx = $urandom;
      ecrc_calc = ($urandom % 2 == 0) ? ecrc_rx : ~ecrc_rx;
      step(5'h00);
    end
    stop_test();
  end
endmodule : testbench
`default_nettype wire
